// ==== hdl/waveform_output_select.sv ====
/*
 * Waveform output selection: phase accumulator, sine or triangle shaping,
 * converter data word, MSB and halved MSB clock output, and the choice of
 * what drives the output pin. Registers sit on an Avalon-MM slave.
 * Assumes a synchronous master on clk and an analogue output stage that
 * switches the pin between the converter and the digital level by
 * pin_digital_select.
 */
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

`include "waveform_output_select_params.svh"

module waveform_output_select
	import waveform_output_select_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	output var  logic [9:0]  dac_data,
	output var  logic        dac_active,
	output var  logic        pin_digital_select,
	output var  logic        waveform_output_pin
);

	wave_state_t state_reg;  // All registered state.
	wave_state_t state_next; // Next value of the state.

	sine_lookup_if sine_bus (); // Link to the sine table.

	logic      req;        // A bus request is present.
	logic      wr_commit;  // A write takes effect at this edge.
	logic      new_req;    // First cycle of a request.
	logic      msb;        // Converter data MSB.
	logic      quad_mirror;// Second or fourth quarter of the phase.
	dac_code_t sine_code;  // Reconstructed sine code.
	dac_code_t tri_code;   // Triangle code from the current phase.

	// Merge one byte lane of write data under its enable.
	function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] wd, input logic en);
		lane = en ? wd : old;
	endfunction : lane

	// Read view of the control word; reserved positions read as zero.
	function automatic logic [31:0] ctrl_view(input wave_state_t s);
		ctrl_view                  = 32'h0000_0000;
		ctrl_view[`WOS_MODE_BIT]   = s.mode;
		ctrl_view[`WOS_HALVE_BIT]  = s.halve_sel;
		ctrl_view[`WOS_DIG_EN_BIT] = s.dig_en;
		ctrl_view[`WOS_PDOWN_BIT]  = s.pdown;
	endfunction : ctrl_view

	// The slave inserts exactly one wait state on every access.
	assign req             = avs_read | avs_write;
	assign new_req         = req & ~state_reg.ack;
	assign wr_commit       = avs_write & state_reg.ack;
	assign avs_waitrequest = req & ~state_reg.ack;

	// The sine table sees a mirrored address in the falling quarters.
	assign quad_mirror   = state_reg.phase[14];
	assign sine_bus.addr = quad_mirror ? ~state_reg.phase[13:9] : state_reg.phase[13:9];

	// Upper half of the cycle goes below mid-scale.
	assign sine_code = state_reg.sign_d ? (`WOS_DAC_MID_LO - {1'b0, sine_bus.mag})
	                                    : (`WOS_DAC_MID_HI + {1'b0, sine_bus.mag});

	// Raw phase folded into a ramp that rises then falls over one cycle.
	assign tri_code = state_reg.phase[15] ? ~state_reg.phase[14:5] : state_reg.phase[14:5];

	assign msb = state_reg.dac[9];

	// Next-state logic for bus, phase path and output selection.
	always_comb begin
		state_next = state_reg;

		// Bus answer: capture read data in the first cycle, answer in the next.
		state_next.ack = new_req;
		if (new_req) begin
			unique case (avs_address)
				`WOS_CTRL_OFS: begin
					state_next.rdata = ctrl_view(state_reg);
				end
				`WOS_PHASE_INC_OFS: begin
					state_next.rdata = {16'h0000, state_reg.inc};
				end
				`WOS_STATUS_OFS: begin
					state_next.rdata                     = {22'h00_0000, state_reg.dac};
					state_next.rdata[`WOS_STAT_MSB_BIT]  = msb;
					state_next.rdata[`WOS_STAT_HALF_BIT] = state_reg.half;
					state_next.rdata[`WOS_STAT_PIN_BIT]  = state_reg.pin;
					state_next.rdata[`WOS_STAT_DIG_BIT]  = state_reg.dig_en;
				end
				default: begin
					// Unmapped addresses read as zero.
					state_next.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Register writes at the answering edge; reserved bits are not stored.
		if (wr_commit) begin
			unique case (avs_address)
				`WOS_CTRL_OFS: begin
					if (avs_byteenable[0]) begin
						state_next.mode      = avs_writedata[`WOS_MODE_BIT];
						state_next.halve_sel = avs_writedata[`WOS_HALVE_BIT];
						state_next.dig_en    = avs_writedata[`WOS_DIG_EN_BIT];
						state_next.pdown     = avs_writedata[`WOS_PDOWN_BIT];
					end
				end
				`WOS_PHASE_INC_OFS: begin
					state_next.inc = {lane(state_reg.inc[15:8], avs_writedata[15:8], avs_byteenable[1]),
					                  lane(state_reg.inc[7:0], avs_writedata[7:0], avs_byteenable[0])};
				end
				default: begin
					// Writes to the status word and unmapped addresses are dropped.
				end
			endcase
		end

		// Phase advances every clock; wrap-around is the cycle boundary.
		state_next.phase  = state_reg.phase + state_reg.inc;
		state_next.sign_d = state_reg.phase[15];
		state_next.tri_d  = tri_code;

		// Converter data: triangle bypasses the table, otherwise the sine code.
		if (state_reg.mode) begin
			state_next.dac = state_reg.tri_d;
		end else begin
			state_next.dac = sine_code;
		end

		// Halved MSB toggles on every rising MSB edge for a square wave.
		state_next.msb_prev = msb;
		state_next.half     = state_reg.half ^ (msb & ~state_reg.msb_prev);

		// Digital level on the pin, held low while the converter owns it.
		if (state_reg.dig_en) begin
			if (state_reg.halve_sel) begin
				state_next.pin = msb;
			end else begin
				state_next.pin = state_reg.half;
			end
		end else begin
			state_next.pin = 1'b0;
		end
	end

	// Single register stage for the whole state; reset clears everything.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg           <= '0;
			state_reg.pdown     <= `WOS_CTRL_RST;
			state_reg.dig_en    <= `WOS_CTRL_RST;
			state_reg.halve_sel <= `WOS_CTRL_RST;
			state_reg.mode      <= `WOS_CTRL_RST;
			state_reg.inc       <= `WOS_PHASE_INC_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// The sine table answers one clock after the address.
	sine_lookup u_sine_lookup (
		.clk     (clk),
		.sys_rst (sys_rst),
		.port    (sine_bus.lookup)
	);

	// Outputs straight from the registered state.
	assign avs_readdata       = state_reg.rdata;
	assign dac_data           = state_reg.dac;
	assign dac_active         = ~state_reg.pdown;
	assign pin_digital_select = state_reg.dig_en;
	assign waveform_output_pin = state_reg.pin;

endmodule : waveform_output_select

`default_nettype wire

// ==== common/waveform_output_select_params.svh ====
/*
 * Constants of the waveform output selection block: register byte offsets,
 * control field positions, reset values and converter geometry.
 * Assumes it is included by its bare name, once or more, before use.
 */
// Functional notes
// - Digital enable routes data MSB to pin.
// - Digital enable clear routes converter to pin.
// - Halving select high passes MSB directly.
// - Halving select low outputs MSB halved.
// - Waveform bit high bypasses sine, gives triangle.
// - Waveform bit low maps phase through sine.
// - Power-down bit high disables the converter.
`ifndef WAVEFORM_OUTPUT_SELECT_PARAMS_SVH
`define WAVEFORM_OUTPUT_SELECT_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave.
`define WOS_CTRL_OFS        4'h0
`define WOS_PHASE_INC_OFS   4'h4
`define WOS_STATUS_OFS      4'h8

// Control word field positions.
`define WOS_MODE_BIT        1
`define WOS_RSVD_LO_BIT     2
`define WOS_HALVE_BIT       3
`define WOS_RSVD_HI_BIT     4
`define WOS_DIG_EN_BIT      5
`define WOS_PDOWN_BIT       6

// Status word field positions.
`define WOS_STAT_MSB_BIT    10
`define WOS_STAT_HALF_BIT   11
`define WOS_STAT_PIN_BIT    12
`define WOS_STAT_DIG_BIT    13

// Reset values.
`define WOS_CTRL_RST        1'b0
`define WOS_PHASE_INC_RST   16'h0000

// Converter mid-scale points for the sine reconstruction.
`define WOS_DAC_MID_HI      10'h200
`define WOS_DAC_MID_LO      10'h1FF

`endif

// ==== common/waveform_output_select_pkg.sv ====
/*
 * Types of the waveform output selection block.
 * Assumes the params header is available on the include path.
 */
package waveform_output_select_pkg;

	// Converter code, phase word and sine table geometry.
	typedef logic [9:0]  dac_code_t;
	typedef logic [15:0] phase_t;
	typedef logic [4:0]  sine_addr_t;
	typedef logic [8:0]  sine_mag_t;

	// Registered state of the selection block.
	typedef struct packed {
		logic      pdown;     // Converter power-down control.
		logic      dig_en;    // Digital output enable control.
		logic      halve_sel; // MSB halving select control.
		logic      mode;      // Waveform select control, 1 = triangle.
		phase_t    inc;       // Phase increment per clock.
		phase_t    phase;     // Phase accumulator.
		logic      sign_d;    // Sine half-cycle sign, aligned to the table output.
		dac_code_t tri_d;     // Triangle code, aligned to the table output.
		dac_code_t dac;       // Converter data word.
		logic      msb_prev;  // Previous converter MSB for edge detection.
		logic      half;      // Halved MSB flip-flop.
		logic      pin;       // Digital level on the output pin.
		logic      ack;       // Bus answer cycle marker.
		logic [31:0] rdata;   // Bus read data.
	} wave_state_t;

	// Registered state of the sine lookup.
	typedef struct packed {
		sine_mag_t mag; // Table magnitude for the last address.
	} lookup_state_t;

endpackage : waveform_output_select_pkg

// ==== common/sine_lookup_if.sv ====
/*
 * Carrier between the selection block and its sine lookup memory.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface sine_lookup_if;
	import waveform_output_select_pkg::*;

	sine_addr_t addr; // Quarter-wave table address.
	sine_mag_t  mag;  // Registered magnitude, one clock after the address.

	modport requester (output addr, input mag);
	modport lookup    (input addr, output mag);
endinterface : sine_lookup_if

`default_nettype wire

// ==== hdl/sine_lookup.sv ====
/*
 * Quarter-wave sine table with registered read data.
 * Assumes the requester mirrors the address and applies the sign itself.
 */
`timescale 1ns/100ps
`default_nettype none

module sine_lookup
	import waveform_output_select_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   sys_rst,
	sine_lookup_if.lookup port
);

	lookup_state_t state_reg;  // Registered table output.
	lookup_state_t state_next; // Next table output.

	// Magnitudes are 511 times the sine at half-step centres, so mirroring is exact.
	function automatic sine_mag_t table_value(input sine_addr_t a);
		unique case (a)
			5'h00: table_value = 9'h00D;
			5'h01: table_value = 9'h026;
			5'h02: table_value = 9'h03F;
			5'h03: table_value = 9'h057;
			5'h04: table_value = 9'h070;
			5'h05: table_value = 9'h088;
			5'h06: table_value = 9'h0A0;
			5'h07: table_value = 9'h0B8;
			5'h08: table_value = 9'h0CF;
			5'h09: table_value = 9'h0E6;
			5'h0A: table_value = 9'h0FC;
			5'h0B: table_value = 9'h111;
			5'h0C: table_value = 9'h126;
			5'h0D: table_value = 9'h13A;
			5'h0E: table_value = 9'h14E;
			5'h0F: table_value = 9'h160;
			5'h10: table_value = 9'h172;
			5'h11: table_value = 9'h183;
			5'h12: table_value = 9'h193;
			5'h13: table_value = 9'h1A2;
			5'h14: table_value = 9'h1B0;
			5'h15: table_value = 9'h1BD;
			5'h16: table_value = 9'h1C8;
			5'h17: table_value = 9'h1D3;
			5'h18: table_value = 9'h1DD;
			5'h19: table_value = 9'h1E5;
			5'h1A: table_value = 9'h1EC;
			5'h1B: table_value = 9'h1F3;
			5'h1C: table_value = 9'h1F7;
			5'h1D: table_value = 9'h1FB;
			5'h1E: table_value = 9'h1FE;
			5'h1F: table_value = 9'h1FF;
		endcase
	endfunction : table_value

	// Look up the magnitude of the presented address.
	always_comb begin
		state_next     = state_reg;
		state_next.mag = table_value(port.addr);
	end

	// Register the read data; reset shows a zero magnitude.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign port.mag = state_reg.mag;

endmodule : sine_lookup

`default_nettype wire

// ==== verification/waveform_output_select_sva.sv ====
/*
 * Checker of the waveform output selection block.
 * Assumes it is bound to the top module and sees its ports only.
 */
`timescale 1ns/100ps
`default_nettype none

module waveform_output_select_sva (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [9:0]  dac_data,
	input wire logic        dac_active,
	input wire logic        pin_digital_select,
	input wire logic        waveform_output_pin
);
	logic [6:0] ctl_reg;  // Control bits as last committed.
	logic       slow_reg; // Increment is one triangle step.
	logic [3:0] age_reg;  // Cycles since the last write, saturating.
	logic       prev_reg; // Converter MSB one cycle back.
	logic       half_reg; // Expected halved MSB.
	wire logic  wr_ok = avs_write && !avs_waitrequest;

	// Shadow the control word so pin checks need no internal signals.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{ctl_reg, slow_reg, age_reg, prev_reg, half_reg} <= '0;
		end else begin
			if (wr_ok && avs_address == 4'h0 && avs_byteenable[0])
				ctl_reg <= avs_writedata[6:0];
			if (wr_ok && avs_address == 4'h4)
				slow_reg <= (avs_writedata[15:0] == 16'h0020);
			age_reg <= wr_ok ? 4'h0 : age_reg + {3'h0, age_reg != 4'hF};
			prev_reg <= dac_data[9];
			half_reg <= half_reg ^ (dac_data[9] & ~prev_reg);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
		else $error("Request not held off in its first cycle.");
	a_wait_once: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("More than one wait state.");
	a_pin_select: assert property (pin_digital_select == ctl_reg[5])
		else $error("Pin source differs from the enable bit.");
	a_conv_pin_low: assert property (!ctl_reg[5] && $past(!ctl_reg[5]) |-> !waveform_output_pin)
		else $error("Digital level high while the converter drives.");
	a_msb_direct: assert property (ctl_reg[5] && ctl_reg[3] && age_reg != 4'h0 |-> waveform_output_pin == $past(dac_data[9]))
		else $error("Pin does not follow the data MSB.");
	a_msb_halved: assert property (ctl_reg[5] && !ctl_reg[3] && age_reg != 4'h0 |-> waveform_output_pin == $past(half_reg))
		else $error("Pin does not follow the halved MSB.");
	a_tri_step: assert property (!ctl_reg[5] && ctl_reg[1] && slow_reg && age_reg > 4'h3 |-> dac_data == $past(dac_data) || dac_data == $past(dac_data) + 10'h001 || dac_data == $past(dac_data) - 10'h001)
		else $error("Triangle code jumps.");
	a_power_down: assert property (dac_active == !ctl_reg[6])
		else $error("Converter power state differs from its bit.");

	// The MSB, halved MSB and triangle modes are each reached at least once; the sine mode has no cover.
	c_msb: cover property (ctl_reg[5] && ctl_reg[3] && $rose(waveform_output_pin));
	c_half: cover property (ctl_reg[5] && !ctl_reg[3] && $rose(waveform_output_pin));
	c_tri: cover property (ctl_reg[1] && slow_reg && age_reg == 4'hF);
endmodule : waveform_output_select_sva

bind waveform_output_select waveform_output_select_sva waveform_output_select_sva_i (.clk(clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.dac_data(dac_data), .dac_active(dac_active), .pin_digital_select(pin_digital_select),
	.waveform_output_pin(waveform_output_pin));

`default_nettype wire

// ==== verification/tb_waveform_output_select.sv ====
/*
 * Self-checking bench of the waveform output selection block.
 * Assumes the design answers each bus access with one wait state.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_waveform_output_select;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [9:0]  dac_data;
	logic        dac_active;
	logic        pin_digital_select;
	logic        waveform_output_pin;
	int          num_errors = 0;
	int          total_checks = 0;
	logic [31:0] seed = 32'd91;   // Xorshift state.
	logic [31:0] exp_q[$];        // Expected read data, oldest first.
	logic [31:0] exp_rd;          // Note taken off the queue for one compare.
	logic [31:0] ctl_t[5] = '{32'h00, 32'h02, 32'h28, 32'h20, 32'h40};
	logic [31:0] inc_t[5] = '{32'h20, 32'h20, 32'h800, 32'h800, 32'h20};
	int          lo_t[5] = '{0, 120, 7, 3, 0};   // Fewest changes allowed.
	int          hi_t[5] = '{16, 128, 9, 5, 16}; // Most changes allowed.

	waveform_output_select waveform_output_select_i (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.dac_data(dac_data), .dac_active(dac_active), .pin_digital_select(pin_digital_select),
		.waveform_output_pin(waveform_output_pin));

	// Free-running 50 MHz clock.
	initial begin
		forever #10 clk = ~clk;
	end

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction : xorshift

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	// One access; waitrequest is sampled at each rising edge, and the request is released only after the edge that sees it low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		{avs_address, avs_writedata, avs_byteenable} <= {a, d, be};
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			n++;
			if (n > 50) begin
				num_errors++;
				tally_and_finish();
			end
		end while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0, 4'hF);
	endtask : rd

	// Read data stands in the answer cycle; the oldest note is matched.
	always @(negedge clk) begin
		// The note is taken off once, so the compare and the message see the same value.
		if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
			exp_rd = exp_q.pop_front();
			`CHK(avs_readdata, exp_rd)
		end
	end

	initial begin
		int cnt;
		logic [9:0] last_d;
		logic last_p;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h0);
		rd(4'hC, 32'h0);
		// Idle status: data word at mid-scale plus the first table entry, MSB high, halved MSB toggled once.
		rd(4'h8, 32'h0000_0E0D);
		seed = xorshift(seed);
		bus(1'b1, 4'h4, seed, 4'hF);
		rd(4'h4, {16'h0, seed[15:0]});
		bus(1'b1, 4'hC, 32'h28, 4'hF);
		bus(1'b1, 4'h0, 32'h28, 4'hE);
		rd(4'h0, 32'h0);
		rd(4'hC, 32'h0);
		// Each mode runs with a rate that makes its output easy to count.
		for (int i = 0; i < 5; i++) begin
			bus(1'b1, 4'h4, inc_t[i], 4'hF);
			bus(1'b1, 4'h0, ctl_t[i], 4'hF);
			rd(4'h0, ctl_t[i]);
			repeat (8) @(negedge clk);
			cnt = 0;
			last_d = dac_data;
			last_p = waveform_output_pin;
			repeat (128) begin
				@(negedge clk);
				cnt += (i < 2) ? int'(dac_data !== last_d) : int'(waveform_output_pin !== last_p);
				last_d = dac_data;
				last_p = waveform_output_pin;
			end
			`CHK(cnt >= lo_t[i] && cnt <= hi_t[i], 1'b1)
			`CHK(pin_digital_select, ctl_t[i][5])
			`CHK(dac_active, !ctl_t[i][6])
		end
		tally_and_finish();
	end
endmodule : tb_waveform_output_select

`default_nettype wire
